// ### common/midi_uart_engine_pkg.sv
// Types shared by the MIDI engine
`include "midi_uart_engine_regs.svh"

package midi_uart_engine_pkg;

   typedef struct packed {
      logic [7:0]                   ctrl;
      logic                         uart;
      logic                         ack;
      logic [`IN_DEPTH-1:0][7:0]    in_mem;
      logic [`IN_AW:0]              in_wp;
      logic [`IN_AW:0]              in_rp;
      logic [`OUT_DEPTH-1:0][7:0]   out_mem;
      logic [1:0]                   out_wp;
      logic [1:0]                   out_rp;
      logic                         tx_busy;
      logic [8:0]                   tx_sh;
      logic [3:0]                   tx_bits;
      logic [`CNT_W-1:0]            tx_cnt;
      logic                         tx_line;
      logic                         rx_busy;
      logic [7:0]                   rx_sh;
      logic [3:0]                   rx_bits;
      logic [`CNT_W-1:0]            rx_cnt;
      logic [2:0]                   sync;
      logic                         pin_line;
      logic [7:0]                   rdata;
      logic                         pad;
   } midi_state_t;

endpackage

// ### common/midi_uart_engine_regs.svh
// Offsets, field positions, reset values and timing of the MIDI engine
`ifndef MIDI_UART_ENGINE_REGS_SVH
`define MIDI_UART_ENGINE_REGS_SVH

// ------------------------------------------------------------
// Port offsets
// ------------------------------------------------------------
`define MIDI_DATA_PORT_OFS    8'h20
`define MIDI_CMD_STATUS_OFS   8'h21
`define MIDI_OP_CTRL_OFS      8'h22
`define MIDI_IN_FIFO_OFS      8'h23

// ------------------------------------------------------------
// Operation control fields
// ------------------------------------------------------------
`define CTL_LOOPBACK_BIT      7
`define CTL_THRU_BIT          6
`define CTL_FAST_CLK_BIT      5
`define CTL_CONNECT_BIT       4
`define CTL_NO_IRQ_BIT        3
`define CTL_FORCE_IDLE_BIT    2
`define CTL_OUT_NEMPTY_BIT    1
`define CTL_IN_NEMPTY_BIT     0
`define CTL_STORED_MASK       8'hfc
`define CTL_RESET             8'h10

// ------------------------------------------------------------
// Command/status fields
// ------------------------------------------------------------
`define STS_NO_DATA_BIT       7
`define STS_OUT_FULL_BIT      6
`define STS_IN_FULL_BIT       5
`define STS_UART_BIT          4
`define STS_RESET             8'h80

// ------------------------------------------------------------
// Commands and answers
// ------------------------------------------------------------
`define CMD_ENTER_UART        8'h3f
`define CMD_MIDI_RESET        8'hff
`define ACK_BYTE              8'hfe
`define IN_FIFO_RESET         8'h00

// ------------------------------------------------------------
// Sizes and timing
// ------------------------------------------------------------
`define IN_DEPTH              16
`define IN_AW                 4
`define OUT_DEPTH             2
`define CORE_CLK_HZ           250000000
`define MIDI_BAUD             31250
`define FAST_CLK_HZ           12288000
`define CNT_W                 13
`define FRAME_BITS            4'h9

`endif

// ### hdl/midi_uart_engine.sv
// MIDI interface engine: host byte ports, two FIFOs, serial in/out pads
//
// Notes on behaviour
// - control bit 7 loops out-FIFO into in-FIFO
// - control bit 6 passes input pad to output
// - control bit 5 selects fast serial clock
// - control bit 4 connects data port to out-FIFO
// - control bit 3 low: interrupt on in-FIFO data
// - control bit 2 forces output pad high
// - in-FIFO port read returns next received byte
// - engine starts in pass-through mode after reset
// - pass-through mode executes only 3Fh and FFh
// - 3Fh enters UART mode, acknowledges, interrupts
// - FFh resets, acknowledges, interrupts, stays pass-through
// - data port read clears acknowledge interrupt
// - UART mode FFh flushes in-FIFO, returns
// - loopback masks status bit 7 from in-FIFO
// - full in-FIFO stops serial clock until one byte is read
// - data read gives acknowledge or input byte
// - loopback data read keeps in-FIFO read pointer
// - status bit 7 low when data available
// - status bit 6 out-FIFO full, bit 5 in-FIFO full
`timescale 1ns/1ps

module midi_uart_engine
   import midi_uart_engine_pkg::*;
#(
   parameter int P_REGULAR_BIT_CYCLES = `CORE_CLK_HZ / `MIDI_BAUD
) (
   input  wire logic       i_core_clk,
   input  wire logic       i_nrst,
   input  wire logic [7:0] i_io_addr,
   input  wire logic       i_io_wr,
   input  wire logic       i_io_rd,
   input  wire logic [7:0] i_io_wdata,
   output logic      [7:0] o_io_rdata,
   output logic            o_irq,
   input  wire logic       i_midi_in,
   output logic            o_midi_out
);

   // ------------------------------------------------------------
   // Constants and helpers
   // ------------------------------------------------------------
   localparam int FAST_BIT_CYCLES_I = `CORE_CLK_HZ / `FAST_CLK_HZ;
   localparam logic [`CNT_W-1:0] REG_CYC  = `CNT_W'(P_REGULAR_BIT_CYCLES);
   localparam logic [`CNT_W-1:0] FAST_CYC = `CNT_W'(FAST_BIT_CYCLES_I);

   function automatic logic [`IN_AW:0] in_fill(input logic [`IN_AW:0] wp,
                                                 input logic [`IN_AW:0] rp);
      in_fill = wp - rp;
   endfunction

   function automatic logic [1:0] out_fill(input logic [1:0] wp,
                                           input logic [1:0] rp);
      out_fill = wp - rp;
   endfunction

   // Empty in-FIFO reads as zero without popping
   function automatic logic [7:0] head_or_zero(input logic       empty,
                                               input logic [7:0] head);
      head_or_zero = empty ? `IN_FIFO_RESET : head;
   endfunction

   function automatic logic [`CNT_W-1:0] count_down(input logic [`CNT_W-1:0] cyc);
      count_down = cyc - `CNT_W'(1);
   endfunction

   midi_state_t s_reg;
   midi_state_t s_next;

   // ------------------------------------------------------------
   // Decoded status
   // ------------------------------------------------------------
   logic              in_empty;
   logic              in_full;
   logic              out_empty;
   logic              out_full;
   logic              loopback;
   logic              run;
   logic [`CNT_W-1:0] bit_cyc;
   logic              rx_src;
   logic [7:0]        status;
   logic [7:0]        ctrl_rd;
   logic [7:0]        in_head;
   logic              out_wr_ready;
   logic              out_rd_valid;
   logic              tx_tick;
   logic              rx_tick;

   always_comb begin
      in_empty  = in_fill(s_reg.in_wp, s_reg.in_rp) == '0;
      in_full   = in_fill(s_reg.in_wp, s_reg.in_rp) == (`IN_AW+1)'(`IN_DEPTH);
      out_empty = out_fill(s_reg.out_wp, s_reg.out_rp) == 2'h0;
      out_full  = out_fill(s_reg.out_wp, s_reg.out_rp) == 2'(`OUT_DEPTH);
      loopback  = s_reg.ctrl[`CTL_LOOPBACK_BIT];
      run       = !in_full;
      out_wr_ready = !out_full;
      out_rd_valid = !out_empty;
      // Bit ticks freeze with the rest of the serial timing
      tx_tick   = run && s_reg.tx_cnt == '0;
      rx_tick   = run && s_reg.rx_cnt == '0;
      bit_cyc   = s_reg.ctrl[`CTL_FAST_CLK_BIT] ? FAST_CYC : REG_CYC;
      rx_src    = loopback ? s_reg.tx_line : s_reg.pin_line;
      in_head   = s_reg.in_mem[s_reg.in_rp[`IN_AW-1:0]];
      status    = 8'h00;
      status[`STS_NO_DATA_BIT]  = !(s_reg.ack || (!loopback && !in_empty));
      status[`STS_OUT_FULL_BIT] = out_full;
      status[`STS_IN_FULL_BIT]  = in_full;
      status[`STS_UART_BIT]     = s_reg.uart;
      ctrl_rd   = s_reg.ctrl & `CTL_STORED_MASK;
      ctrl_rd[`CTL_OUT_NEMPTY_BIT] = !out_empty;
      ctrl_rd[`CTL_IN_NEMPTY_BIT]  = !in_empty;
   end

   // ------------------------------------------------------------
   // Port address decode
   // ------------------------------------------------------------
   logic sel_data;
   logic sel_cmd;
   logic sel_ctrl;
   logic sel_fifo;

   // One select at most; unmapped addresses select nothing
   always_comb begin
      sel_data = 1'b0;
      sel_cmd  = 1'b0;
      sel_ctrl = 1'b0;
      sel_fifo = 1'b0;
      if (i_io_addr == `MIDI_DATA_PORT_OFS) begin
         sel_data = 1'b1;
      end else if (i_io_addr == `MIDI_CMD_STATUS_OFS) begin
         sel_cmd = 1'b1;
      end else if (i_io_addr == `MIDI_OP_CTRL_OFS) begin
         sel_ctrl = 1'b1;
      end else if (i_io_addr == `MIDI_IN_FIFO_OFS) begin
         sel_fifo = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   logic wr_data;
   logic wr_cmd;
   logic rd_data;
   logic rd_fifo;
   logic wr_ctrl;
   logic rd_sts;
   logic rd_ctrl;
   logic in_push;
   logic in_pop;
   logic out_push;
   logic out_pop;
   logic flush_in;
   logic flush_out;
   logic ack_set;

   always_comb begin
      s_next   = s_reg;
      wr_data  = i_io_wr && sel_data;
      wr_cmd   = i_io_wr && sel_cmd;
      wr_ctrl  = i_io_wr && sel_ctrl;
      rd_data  = i_io_rd && sel_data;
      rd_sts   = i_io_rd && sel_cmd;
      rd_ctrl  = i_io_rd && sel_ctrl;
      rd_fifo  = i_io_rd && sel_fifo;
      in_push  = 1'b0;
      in_pop   = 1'b0;
      out_push = 1'b0;
      out_pop  = 1'b0;
      flush_in = 1'b0;
      flush_out = 1'b0;
      ack_set  = 1'b0;

      // Operation control write
      if (wr_ctrl) begin
         s_next.ctrl = i_io_wdata & `CTL_STORED_MASK;
      end

      // Command decode
      if (wr_cmd) begin
         if (!s_reg.uart) begin
            if (i_io_wdata == `CMD_ENTER_UART) begin
               s_next.uart = 1'b1;
               ack_set     = 1'b1;
            end else if (i_io_wdata == `CMD_MIDI_RESET) begin
               flush_in  = 1'b1;
               flush_out = 1'b1;
               ack_set   = 1'b1;
            end
         end else if (i_io_wdata == `CMD_MIDI_RESET) begin
            flush_in    = 1'b1;
            s_next.uart = 1'b0;
         end
      end

      // Data port write into out-FIFO
      if (wr_data && (s_reg.uart || s_reg.ctrl[`CTL_CONNECT_BIT]) && out_wr_ready) begin
         out_push = 1'b1;
      end

      // Host reads, answer the following cycle
      if (rd_data) begin
         if (s_reg.ack) begin
            s_next.rdata = `ACK_BYTE;
            s_next.ack   = 1'b0;
         end else begin
            s_next.rdata = head_or_zero(in_empty, in_head);
            in_pop       = !in_empty && !loopback;
         end
      end else if (rd_fifo) begin
         s_next.rdata = head_or_zero(in_empty, in_head);
         in_pop       = !in_empty;
      end else if (rd_sts) begin
         s_next.rdata = status;
      end else if (rd_ctrl) begin
         s_next.rdata = ctrl_rd;
      end else if (i_io_rd) begin
         s_next.rdata = 8'h00;
      end

      // Set wins over a clear in the same cycle
      if (ack_set) begin
         s_next.ack = 1'b1;
      end

      // Transmitter, 8N1, LSB first
      if (run && s_reg.tx_cnt != '0) begin
         s_next.tx_cnt = count_down(s_reg.tx_cnt);
      end
      if (!s_reg.tx_busy) begin
         if (out_rd_valid && run) begin
            out_pop        = 1'b1;
            s_next.tx_busy = 1'b1;
            s_next.tx_line = 1'b0;
            s_next.tx_sh   = {1'b1, s_reg.out_mem[s_reg.out_rp[0]]};
            s_next.tx_bits = `FRAME_BITS;
            s_next.tx_cnt  = count_down(bit_cyc);
         end
      end else if (tx_tick) begin
         if (s_reg.tx_bits == 4'h0) begin
            s_next.tx_busy = 1'b0;
         end else begin
            s_next.tx_line = s_reg.tx_sh[0];
            s_next.tx_sh   = {1'b1, s_reg.tx_sh[8:1]};
            s_next.tx_bits = s_reg.tx_bits - 4'h1;
            s_next.tx_cnt  = count_down(bit_cyc);
         end
      end

      // Input pad: three stages, change taken when last two agree
      s_next.sync = {s_reg.sync[1:0], i_midi_in};
      if (s_reg.sync[1] == s_reg.sync[2]) begin
         s_next.pin_line = s_reg.sync[2];
      end

      // Receiver, sampling mid-bit
      if (run && s_reg.rx_cnt != '0) begin
         s_next.rx_cnt = count_down(s_reg.rx_cnt);
      end
      if (!s_reg.rx_busy) begin
         if (!rx_src && run) begin
            s_next.rx_busy = 1'b1;
            s_next.rx_bits = 4'h0;
            s_next.rx_cnt  = count_down(bit_cyc >> 1);
         end
      end else if (rx_tick) begin
         s_next.rx_cnt = count_down(bit_cyc);
         if (s_reg.rx_bits == 4'h0) begin
            if (rx_src) begin
               s_next.rx_busy = 1'b0;
            end else begin
               s_next.rx_bits = 4'h1;
            end
         end else if (s_reg.rx_bits < `FRAME_BITS) begin
            s_next.rx_sh   = {rx_src, s_reg.rx_sh[7:1]};
            s_next.rx_bits = s_reg.rx_bits + 4'h1;
         end else begin
            s_next.rx_busy = 1'b0;
            in_push        = rx_src && !in_full;
         end
      end

      // In-FIFO pointers
      if (in_push) begin
         s_next.in_mem[s_reg.in_wp[`IN_AW-1:0]] = s_reg.rx_sh;
         s_next.in_wp = s_reg.in_wp + (`IN_AW+1)'(1);
      end
      if (in_pop) begin
         s_next.in_rp = s_reg.in_rp + (`IN_AW+1)'(1);
      end
      if (flush_in) begin
         s_next.in_rp = s_next.in_wp;
      end

      // Out-FIFO, two entries, host stalls on status bit 6
      if (out_push) begin
         s_next.out_mem[s_reg.out_wp[0]] = i_io_wdata;
         s_next.out_wp = s_reg.out_wp + 2'h1;
      end
      if (out_pop) begin
         s_next.out_rp = s_reg.out_rp + 2'h1;
      end
      if (flush_out) begin
         s_next.out_rp = s_next.out_wp;
      end

      // Output pad selection
      if (s_reg.ctrl[`CTL_FORCE_IDLE_BIT]) begin
         s_next.pad = 1'b1;
      end else if (s_reg.ctrl[`CTL_THRU_BIT]) begin
         s_next.pad = s_reg.pin_line;
      end else begin
         s_next.pad = s_reg.tx_line;
      end
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         s_reg          <= '0;
         s_reg.ctrl     <= `CTL_RESET;
         s_reg.uart     <= 1'b0;
         s_reg.tx_line  <= 1'b1;
         s_reg.sync     <= 3'h7;
         s_reg.pin_line <= 1'b1;
         s_reg.pad      <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign o_io_rdata = s_reg.rdata;
   assign o_midi_out = s_reg.pad;
   assign o_irq      = s_reg.ack ||
                       (!s_reg.ctrl[`CTL_NO_IRQ_BIT] && !in_empty);

endmodule

// ### verification/midi_instrument_model.sv
// External MIDI instrument: serial sender and receiver
`timescale 1ns/1ps
module midi_instrument_model (
   input wire logic i_core_clk,
   input wire logic i_line,
   output logic     o_line
);
   int         bit_cycles = 40;
   int         n_rx = 0;
   logic [7:0] rx_byte = 8'h00;
   logic [7:0] sh;
   initial o_line = 1'b1;
   task automatic send(input logic [7:0] b);
      @(posedge i_core_clk);
      o_line <= 1'b0;
      repeat (bit_cycles) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
         o_line <= b[i];
         repeat (bit_cycles) @(posedge i_core_clk);
      end
      o_line <= 1'b1;
      repeat (3 * bit_cycles) @(posedge i_core_clk);
   endtask
   // Mid-bit sampling of frames from the pad
   always begin
      @(negedge i_line);
      repeat (bit_cycles / 2) @(posedge i_core_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cycles) @(posedge i_core_clk);
         sh[i] = i_line;
      end
      repeat (bit_cycles) @(posedge i_core_clk);
      if (i_line) begin
         rx_byte = sh;
         n_rx++;
      end
   end
endmodule

// ### verification/midi_uart_engine_checker.sv
// Port assertions for the MIDI engine
`timescale 1ns/1ps
module midi_uart_engine_checker (
   input wire logic       i_core_clk,
   input wire logic       i_nrst,
   input wire logic [7:0] i_io_addr,
   input wire logic       i_io_wr,
   input wire logic       i_io_rd,
   input wire logic [7:0] i_io_wdata,
   input wire logic [7:0] o_io_rdata,
   input wire logic       o_irq,
   input wire logic       i_midi_in,
   input wire logic       o_midi_out
);
   logic [7:0] ctrl_reg;
   logic       uart_reg;
   logic       ack_reg;
   logic       cmd;
   logic       rd_data;
   logic       rd_sts;
   assign cmd     = i_io_wr && i_io_addr == 8'h21;
   assign rd_data = i_io_rd && i_io_addr == 8'h20 && !i_io_wr;
   assign rd_sts  = i_io_rd && i_io_addr == 8'h21 && !i_io_wr;
   // Shadow of mode, acknowledge and control
   always_ff @(posedge i_core_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         ctrl_reg <= 8'h10;
         uart_reg <= 1'b0;
         ack_reg  <= 1'b0;
      end else begin
         if (i_io_wr && i_io_addr == 8'h22) ctrl_reg <= i_io_wdata;
         if (cmd && i_io_wdata == 8'hff) uart_reg <= 1'b0;
         else if (cmd && i_io_wdata == 8'h3f) uart_reg <= 1'b1;
         if (cmd && !uart_reg && (i_io_wdata == 8'h3f || i_io_wdata == 8'hff)) ack_reg <= 1'b1;
         else if (i_io_rd && i_io_addr == 8'h20) ack_reg <= 1'b0;
      end
   end
   // ----
   // Assertions
   // ----
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_nrst);
   a_reset_quiet: assert property ($rose(i_nrst) |-> o_midi_out && !o_irq)
      else $error("pad or irq active after reset");
   a_enter_irq: assert property (cmd && !uart_reg && i_io_wdata == 8'h3f |=> o_irq)
      else $error("no irq on enter");
   a_reset_irq: assert property (cmd && !uart_reg && i_io_wdata == 8'hff |=> o_irq)
      else $error("no irq on midi reset");
   a_ack_data: assert property (rd_data && ack_reg |=> o_io_rdata == 8'hfe)
      else $error("ack byte wrong");
   a_ack_status: assert property (rd_sts && ack_reg |=> !o_io_rdata[7])
      else $error("status hides ack");
   a_mode_status: assert property (rd_sts |=> o_io_rdata[4] == uart_reg)
      else $error("mode flag wrong");
   a_ack_release: assert property (rd_data && ack_reg && ctrl_reg[3] |=> !o_irq)
      else $error("irq kept after ack read");
   a_irq_masked: assert property (ctrl_reg[3] && !ack_reg |-> !o_irq)
      else $error("irq while masked");
   a_ctrl_read: assert property (i_io_rd && i_io_addr == 8'h22 && !i_io_wr
      |=> o_io_rdata[7:2] == ctrl_reg[7:2])
      else $error("control readback wrong");
   a_force_idle: assert property (ctrl_reg[2] && $past(ctrl_reg[2]) |-> o_midi_out)
      else $error("pad low while forced idle");
   a_rdata_hold: assert property (!i_io_rd |=> $stable(o_io_rdata))
      else $error("read data moved");
endmodule
bind midi_uart_engine midi_uart_engine_checker midi_uart_engine_checker_i (
   .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_io_addr(i_io_addr),
   .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
   .o_io_rdata(o_io_rdata), .o_irq(o_irq), .i_midi_in(i_midi_in),
   .o_midi_out(o_midi_out));

// ### verification/midi_uart_engine_test.sv
// Self-checking bench for the MIDI engine
`timescale 1ns/1ps
module midi_uart_engine_test;
   logic       i_core_clk = 1'b0;
   logic       i_nrst     = 1'b0;
   logic [7:0] i_io_addr  = 8'h00;
   logic       i_io_wr    = 1'b0;
   logic       i_io_rd    = 1'b0;
   logic [7:0] i_io_wdata = 8'h00;
   logic [7:0] o_io_rdata;
   logic       o_irq;
   logic       i_midi_in;
   logic       o_midi_out;
   logic [7:0] rv;
   int         n_errors   = 0;
   int         n_checks   = 0;
   int         cycles     = 0;
   always #2 i_core_clk = ~i_core_clk;
   midi_uart_engine #(.P_REGULAR_BIT_CYCLES(40)) midi_uart_engine_i (
      .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_io_addr(i_io_addr),
      .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
      .o_io_rdata(o_io_rdata), .o_irq(o_irq), .i_midi_in(i_midi_in),
      .o_midi_out(o_midi_out));
   midi_instrument_model midi_instrument_model_i (
      .i_core_clk(i_core_clk), .i_line(o_midi_out), .o_line(i_midi_in));
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("unexpected at %0t ns: run too long", $time);
         test_done;
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t ns: %s", $time, what);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_io_addr  <= a;
      i_io_wdata <= d;
      i_io_wr    <= 1'b1;
      @(posedge i_core_clk);
      i_io_wr <= 1'b0;
      @(negedge i_core_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge i_core_clk);
      i_io_addr <= a;
      i_io_rd   <= 1'b1;
      @(posedge i_core_clk);
      i_io_rd <= 1'b0;
      @(negedge i_core_clk);
      rv = o_io_rdata;
   endtask
   task automatic poll(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
      int k;
      k = 0;
      rd(a);
      while ((rv & m) !== v && k < 3000) begin
         rd(a);
         k++;
      end
      chk(rv & m, v, "wait ran out");
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_reset;
      rd(8'h21);
      chk(rv, 8'h80, "status");
      rd(8'h22);
      chk(rv, 8'h10, "control");
      rd(8'h23);
      chk(rv, 8'h00, "fifo port");
      chk({7'h0, o_irq}, 8'h00, "irq after reset");
      $display("reset test done");
   endtask
   task automatic t_cmd;
      wr(8'h21, 8'h01);
      chk({7'h0, o_irq}, 8'h00, "stray irq");
      wr(8'h21, 8'h3f);
      chk({7'h0, o_irq}, 8'h01, "enter irq");
      rd(8'h21);
      chk(rv & 8'h90, 8'h10, "uart flag");
      rd(8'h20);
      chk(rv, 8'hfe, "ack");
      chk({7'h0, o_irq}, 8'h00, "irq kept");
      wr(8'h21, 8'h3f);
      wr(8'h21, 8'hff);
      rd(8'h21);
      chk(rv & 8'h90, 8'h80, "leave uart");
      wr(8'h21, 8'hff);
      rd(8'h20);
      chk(rv, 8'hfe, "reset ack");
      rd(8'h21);
      chk(rv & 8'h90, 8'h80, "stay");
      $display("command test done");
   endtask
   task automatic t_tx(input int p, input logic [7:0] c, input logic [7:0] b, input int n);
      int m;
      midi_instrument_model_i.bit_cycles = p;
      wr(8'h22, c);
      m = midi_instrument_model_i.n_rx;
      wr(8'h20, b);
      repeat (12 * p) @(posedge i_core_clk);
      chk(8'(midi_instrument_model_i.n_rx - m), 8'(n), "frame count");
      if (n == 1) chk(midi_instrument_model_i.rx_byte, b, "sent byte");
      $display("transmit test done");
   endtask
   task automatic t_rx;
      midi_instrument_model_i.bit_cycles = 20;
      wr(8'h22, 8'h30);
      midi_instrument_model_i.send(8'h5a);
      chk({7'h0, o_irq}, 8'h01, "rx irq");
      rd(8'h21);
      chk(rv & 8'h80, 8'h00, "rx avail");
      rd(8'h23);
      chk(rv, 8'h5a, "rx byte");
      chk({7'h0, o_irq}, 8'h00, "irq left");
      wr(8'h22, 8'h38);
      midi_instrument_model_i.send(8'hc3);
      chk({7'h0, o_irq}, 8'h00, "masked irq");
      rd(8'h22);
      chk(rv & 8'h01, 8'h01, "rx held");
      wr(8'h21, 8'h3f);
      rd(8'h20);
      wr(8'h21, 8'hff);
      rd(8'h22);
      chk(rv & 8'h01, 8'h00, "flush");
      $display("receive test done");
   endtask
   task automatic t_thru;
      midi_instrument_model_i.bit_cycles = 40;
      wr(8'h22, 8'h58);
      midi_instrument_model_i.send(8'h96);
      chk(midi_instrument_model_i.rx_byte, 8'h96, "echo");
      rd(8'h23);
      chk(rv, 8'h96, "pad byte");
      $display("thru test done");
   endtask
   task automatic t_full;
      midi_instrument_model_i.bit_cycles = 20;
      wr(8'h22, 8'hb8);
      for (logic [7:0] i = 8'h00; i < 8'h12; i++) begin
         poll(8'h21, 8'h40, 8'h00);
         wr(8'h20, 8'h40 + i);
      end
      poll(8'h21, 8'h20, 8'h20);
      rd(8'h21);
      chk(rv & 8'he0, 8'he0, "full flags");
      rd(8'h20);
      chk(rv, 8'h40, "peek");
      rd(8'h20);
      chk(rv, 8'h40, "no pop");
      for (logic [7:0] i = 8'h00; i < 8'h12; i++) begin
         poll(8'h22, 8'h01, 8'h01);
         rd(8'h23);
         chk(rv, 8'h40 + i, "loop byte");
      end
      rd(8'h22);
      chk(rv & 8'h03, 8'h00, "drained");
      $display("fifo test done");
   endtask
   task automatic t_rst_mid;
      wr(8'h21, 8'h3f);
      chk({7'h0, o_irq}, 8'h01, "ack before reset");
      @(posedge i_core_clk);
      i_nrst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_reset;
   endtask
   initial begin
      repeat (4) @(posedge i_core_clk);
      i_nrst <= 1'b1;
      t_reset;
      t_cmd;
      t_tx(40, 8'h18, 8'h3c, 1);
      t_tx(20, 8'h38, 8'hc5, 1);
      t_tx(20, 8'h28, 8'h11, 0);
      t_tx(20, 8'h3c, 8'h22, 0);
      t_rx;
      t_thru;
      t_full;
      t_rst_mid;
      test_done;
   end
endmodule
